/* bbx_pkg.sv */
// Shared types and constants of the bit-test branch and CPU control execution unit.
// Assumes a single clock domain; nothing here holds state or logic.
package bbx_pkg;

    // Instruction classes handled by the unit.
    typedef enum logic [3:0] {
        op_bit_set, op_bit_zero, op_set_clear, op_dec_branch, op_bank_choice,
        op_no_action, op_irq_enable, op_irq_mask_all, op_clock_pause, op_osc_off,
        op_word_move
    } op_t;

    // Operand areas; the short direct and pointer areas may be slow memory.
    typedef enum logic [2:0] {
        area_short_direct, area_sfr, area_accum, area_status, area_pointer,
        area_reg_b, area_reg_c
    } area_t;

    // Instruction lengths in bytes.
    localparam logic [2:0] LEN_ONE   = 3'h1;
    localparam logic [2:0] LEN_TWO   = 3'h2;
    localparam logic [2:0] LEN_THREE = 3'h3;
    localparam logic [2:0] LEN_FOUR  = 3'h4;

    // Instruction clock counts in CPU clock cycles.
    localparam logic [3:0] CLK_TWO    = 4'h2;
    localparam logic [3:0] CLK_FOUR   = 4'h4;
    localparam logic [3:0] CLK_SIX    = 4'h6;
    localparam logic [3:0] CLK_EIGHT  = 4'h8;
    localparam logic [3:0] CLK_NINE   = 4'h9;
    localparam logic [3:0] CLK_TEN    = 4'ha;
    localparam logic [3:0] CLK_ELEVEN = 4'hb;
    localparam logic [3:0] CLK_TWELVE = 4'hc;

    // Word move check: length and clocks used for its completion.
    localparam logic [2:0] LEN_WORD_MOVE = 3'h1;
    localparam logic [3:0] CLK_WORD_MOVE = 4'h4;
    localparam logic [1:0] PAIR_AX       = 2'h0;

    // Status word layout and reset value.
    localparam int unsigned PSW_IRQ_POS   = 7;
    localparam int unsigned PSW_ZERO_POS  = 6;
    localparam int unsigned PSW_BANK1_POS = 5;
    localparam int unsigned PSW_AUX_POS   = 4;
    localparam int unsigned PSW_BANK0_POS = 3;
    localparam int unsigned PSW_CARRY_POS = 0;
    localparam logic [7:0]  PSW_RESET     = 8'h02;

endpackage : bbx_pkg

/* bbx_bit_pick.sv */
// Picks one bit of a byte and forms the byte with that bit cleared.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module bbx_bit_pick (
    input  wire logic [7:0] i_byte,
    input  wire logic [2:0] i_sel,
    output logic            o_bit,
    output logic [7:0]      o_cleared
);
    // Selected bit and the cleared copy of the byte.
    assign o_bit     = i_byte[i_sel];
    assign o_cleared = i_byte & ~(8'h01 << i_sel);
endmodule : bbx_bit_pick

/* bbx_cycle_timer.sv */
// Counts an instruction's CPU clocks in system clocks, scaled by the divider.
// Assumes a load only arrives while the timer is idle.
`timescale 1ns/1ps
module bbx_cycle_timer (
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_load,
    input  wire logic [3:0] i_clocks,
    input  wire logic [1:0] i_div_sel,
    output logic            o_busy,
    output logic            o_last
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] span;

    // One CPU clock lasts two to the power of the divider choice system clocks.
    assign span   = {4'h0, i_clocks} << i_div_sel;
    assign o_busy = cnt_q != 8'h00;
    assign o_last = cnt_q == 8'h01;
    assign cnt_d  = i_load ? span : (o_busy ? cnt_q - 8'h01 : cnt_q);

    // Down counter; zero means idle.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // The timer is always idle in the cycle after its last busy cycle.
    timer_last_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        o_last |=> !o_busy)
        else $error("Timer stayed busy after its last cycle.");
endmodule : bbx_cycle_timer

/* bbx_exec.sv */
// Execution unit for bit-test branches, decrement loops and CPU control.
// Assumes the fetch side hands over one decoded instruction with its operand
// byte, and takes the write-back strobe when the instruction completes.
`timescale 1ns/1ps

// Function
// RULE1 - Clock counts are CPU clocks chosen by the divider selection input.
// RULE2 - Fast count for high-speed RAM or no data access, slow count otherwise.
// RULE3 - Bit-set branch on short direct bit: 3 bytes, 8 or 9 clocks.
// RULE4 - Bit-set branch on special register bit: 4 bytes, 11 clocks.
// RULE5 - Bit-set and bit-zero branches on accumulator bit: 3 bytes, 8 clocks.
// RULE6 - Bit-set branch on status word bit: 3 bytes, 9 clocks.
// RULE7 - Bit branches through pointer pair: 3 bytes, 10 or 11 clocks.
// RULE8 - Bit-zero branch on short direct bit: 4 bytes, 10 or 11 clocks.
// RULE9 - Bit-zero branch on special register or status bit: 4 bytes, 11 clocks.
// RULE10 - Set-and-clear branch only on a one bit, clears it; special form 12.
// RULE11 - Set-and-clear on status word changes zero, aux carry and carry flags.
// RULE12 - Loop on register B or C: 2 bytes, 6 clocks, branch if nonzero.
// RULE13 - Loop on short direct byte: 3 bytes, 8 or 10 clocks.
// RULE14 - Bank choice: 2 bytes, 4 clocks, writes the two bank bits.
// RULE15 - No-action instruction: 1 byte, 2 clocks, changes nothing.
// RULE16 - Interrupt enable: 2 bytes, 6 clocks, sets the global enable flag.
// RULE17 - Interrupt mask-all: 2 bytes, 6 clocks, clears the global enable flag.
// RULE18 - Clock pause: 2 bytes, 6 clocks, enters clock pause standby.
// RULE19 - Oscillator off: 2 bytes, 6 clocks, enters oscillator-off standby.
// RULE20 - Word move with AX accepts only pairs BC, DE or HL.
// RULE21 - Offset is signed 8-bit, added to the next instruction address.
module bbx_exec (
    input  wire logic             i_sys_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_start,
    input  wire bbx_pkg::op_t     i_op,
    input  wire bbx_pkg::area_t   i_area,
    input  wire logic             i_hs_ram,
    input  wire logic [2:0]       i_bit_sel,
    input  wire logic [7:0]       i_operand,
    input  wire logic [7:0]       i_relative_offset,
    input  wire logic [15:0]      i_pc,
    input  wire logic [1:0]       i_bank_sel,
    input  wire logic [1:0]       i_word_pair,
    input  wire logic [1:0]       i_cpu_clock_divider_select,
    input  wire logic             i_wake,
    output logic                  o_ready,
    output logic                  o_done,
    output logic [2:0]            o_length,
    output logic [3:0]            o_clocks,
    output logic [15:0]           o_pc_next,
    output logic                  o_branch_taken,
    output logic                  o_wr_en,
    output bbx_pkg::area_t        o_wr_area,
    output logic [7:0]            o_wr_data,
    output logic [7:0]            o_program_status_word,
    output logic                  o_global_irq_enable_flag,
    output logic [1:0]            o_bank_choice_bits,
    output logic                  o_clock_pause,
    output logic                  o_osc_off,
    output logic                  o_illegal
);

    // Length in bytes, fast count and slow count of one instruction form.
    function automatic logic [10:0] form_timing(input bbx_pkg::op_t op,
                                                input bbx_pkg::area_t ar);
        logic [10:0] t;
        t = {bbx_pkg::LEN_TWO, bbx_pkg::CLK_SIX, bbx_pkg::CLK_SIX};
        unique case (op)
            bbx_pkg::op_bit_set: begin
                unique case (ar)
                    bbx_pkg::area_short_direct: // see RULE3
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_EIGHT, bbx_pkg::CLK_NINE};
                    bbx_pkg::area_sfr: // see RULE4
                        t = {bbx_pkg::LEN_FOUR, bbx_pkg::CLK_ELEVEN, bbx_pkg::CLK_ELEVEN};
                    bbx_pkg::area_status: // see RULE6
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_NINE, bbx_pkg::CLK_NINE};
                    bbx_pkg::area_pointer: // see RULE7
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_TEN, bbx_pkg::CLK_ELEVEN};
                    default: // see RULE5
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_EIGHT, bbx_pkg::CLK_EIGHT};
                endcase
            end
            bbx_pkg::op_bit_zero: begin
                unique case (ar)
                    bbx_pkg::area_short_direct: // see RULE8
                        t = {bbx_pkg::LEN_FOUR, bbx_pkg::CLK_TEN, bbx_pkg::CLK_ELEVEN};
                    bbx_pkg::area_sfr, bbx_pkg::area_status: // see RULE9
                        t = {bbx_pkg::LEN_FOUR, bbx_pkg::CLK_ELEVEN, bbx_pkg::CLK_ELEVEN};
                    bbx_pkg::area_pointer: // see RULE7
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_TEN, bbx_pkg::CLK_ELEVEN};
                    default: // see RULE5
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_EIGHT, bbx_pkg::CLK_EIGHT};
                endcase
            end
            bbx_pkg::op_set_clear: begin
                unique case (ar)
                    bbx_pkg::area_short_direct:
                        t = {bbx_pkg::LEN_FOUR, bbx_pkg::CLK_TEN, bbx_pkg::CLK_TWELVE};
                    bbx_pkg::area_sfr, bbx_pkg::area_status: // see RULE10
                        t = {bbx_pkg::LEN_FOUR, bbx_pkg::CLK_TWELVE, bbx_pkg::CLK_TWELVE};
                    bbx_pkg::area_pointer:
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_TEN, bbx_pkg::CLK_TWELVE};
                    default:
                        t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_EIGHT, bbx_pkg::CLK_EIGHT};
                endcase
            end
            bbx_pkg::op_dec_branch: begin
                if (ar == bbx_pkg::area_short_direct) begin // see RULE13
                    t = {bbx_pkg::LEN_THREE, bbx_pkg::CLK_EIGHT, bbx_pkg::CLK_TEN};
                end else begin // see RULE12
                    t = {bbx_pkg::LEN_TWO, bbx_pkg::CLK_SIX, bbx_pkg::CLK_SIX};
                end
            end
            bbx_pkg::op_bank_choice: // see RULE14
                t = {bbx_pkg::LEN_TWO, bbx_pkg::CLK_FOUR, bbx_pkg::CLK_FOUR};
            bbx_pkg::op_no_action: // see RULE15
                t = {bbx_pkg::LEN_ONE, bbx_pkg::CLK_TWO, bbx_pkg::CLK_TWO};
            bbx_pkg::op_word_move:
                t = {bbx_pkg::LEN_WORD_MOVE, bbx_pkg::CLK_WORD_MOVE, bbx_pkg::CLK_WORD_MOVE};
            default: // see RULE16 see RULE17 see RULE18 see RULE19
                t = {bbx_pkg::LEN_TWO, bbx_pkg::CLK_SIX, bbx_pkg::CLK_SIX};
        endcase
        return t;
    endfunction : form_timing

    logic            busy;
    logic            last;
    logic            accept;
    logic            slow_area;
    logic [10:0]     timing;
    logic [3:0]      clocks;
    logic [2:0]      length;
    logic [7:0]      src_byte;
    logic            src_bit;
    logic [7:0]      src_cleared;
    logic            psw_bit;
    logic [7:0]      psw_cleared;
    logic [7:0]      dec_byte;
    logic            cond;
    logic            pair_ok;
    logic [15:0]     pc_seq;
    logic [15:0]     pc_target;
    logic            writes;
    logic [7:0]      wr_byte;
    logic            is_status;
    logic [7:0]      psw_q;
    logic [7:0]      psw_d;
    bbx_pkg::op_t    op_q;
    logic            status_q;
    logic [2:0]      bit_q;
    logic [1:0]      bank_q;
    logic            wr_pend_q;
    logic            pause_q;
    logic            osc_q;
    logic [1:0]      div_q;
    logic [7:0]      elapsed_q;

    // A new instruction is taken only when idle and not in standby.
    assign o_ready = !busy && !pause_q && !osc_q;
    assign accept  = i_start && o_ready;
    assign o_done  = last;
    assign o_wr_en = last && wr_pend_q;

    // Slow count applies when a short direct or pointer access misses fast RAM.
    assign slow_area = (i_area == bbx_pkg::area_short_direct ||
                        i_area == bbx_pkg::area_pointer) && !i_hs_ram; // see RULE2
    assign timing    = form_timing(i_op, i_area);
    assign clocks    = slow_area ? timing[3:0] : timing[7:4]; // see RULE2
    assign length    = timing[10:8];

    // Bit operand comes from the status word for status forms, else the bus byte.
    assign is_status = i_area == bbx_pkg::area_status;
    assign src_byte  = is_status ? psw_q : i_operand;

    bbx_bit_pick u_src_pick (
        .i_byte    (src_byte),
        .i_sel     (i_bit_sel),
        .o_bit     (src_bit),
        .o_cleared (src_cleared)
    );

    // The status word clear is formed again at completion from the live word.
    bbx_bit_pick u_psw_pick (
        .i_byte    (psw_q),
        .i_sel     (bit_q),
        .o_bit     (psw_bit),
        .o_cleared (psw_cleared)
    );

    // Branch condition per class; the loop decrements before testing.
    assign dec_byte = i_operand - 8'h01; // see RULE12 see RULE13
    assign cond = (i_op == bbx_pkg::op_bit_set)    ? src_bit :
                  (i_op == bbx_pkg::op_bit_zero)   ? !src_bit : // see RULE8 see RULE9
                  (i_op == bbx_pkg::op_set_clear)  ? src_bit : // see RULE10
                  (i_op == bbx_pkg::op_dec_branch) ? dec_byte != 8'h00 : 1'b0;

    // Target is the next instruction address plus the sign-extended offset.
    assign pc_seq    = i_pc + {13'h0000, length};
    assign pc_target = pc_seq + {{8{i_relative_offset[7]}}, i_relative_offset}; // see RULE21

    // Only the listed pairs may move a word with AX.
    assign pair_ok = i_word_pair != bbx_pkg::PAIR_AX; // see RULE20

    // Write-back: loop result, or the cleared bit of a taken set-and-clear outside the status word.
    assign writes  = (i_op == bbx_pkg::op_dec_branch) ||
                     (i_op == bbx_pkg::op_set_clear && src_bit && !is_status);
    assign wr_byte = (i_op == bbx_pkg::op_dec_branch) ? dec_byte : src_cleared;

    // Status word update at completion; only the completing class may touch it.
    always_comb begin
        psw_d = psw_q;
        if (last) begin
            unique case (op_q)
                bbx_pkg::op_set_clear: begin
                    if (status_q && psw_bit) begin
                        psw_d = psw_cleared; // see RULE10 see RULE11
                    end
                end
                bbx_pkg::op_bank_choice: begin
                    psw_d[bbx_pkg::PSW_BANK1_POS] = bank_q[1]; // see RULE14
                    psw_d[bbx_pkg::PSW_BANK0_POS] = bank_q[0];
                end
                bbx_pkg::op_irq_enable:   psw_d[bbx_pkg::PSW_IRQ_POS] = 1'b1; // see RULE16
                bbx_pkg::op_irq_mask_all: psw_d[bbx_pkg::PSW_IRQ_POS] = 1'b0; // see RULE17
                default:                  psw_d = psw_q; // see RULE15
            endcase
        end
    end

    // Clocks are counted in CPU clocks scaled by the divider choice.
    bbx_cycle_timer u_timer (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_load    (accept),
        .i_clocks  (clocks),
        .i_div_sel (i_cpu_clock_divider_select), // see RULE1
        .o_busy    (busy),
        .o_last    (last)
    );

    // Results are captured when the instruction is taken.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            op_q           <= bbx_pkg::op_no_action;
            status_q       <= 1'b0;
            bit_q          <= 3'h0;
            bank_q         <= 2'h0;
            wr_pend_q      <= 1'b0;
            div_q          <= 2'h0;
            o_length       <= 3'h0;
            o_clocks       <= 4'h0;
            o_pc_next      <= 16'h0000;
            o_branch_taken <= 1'b0;
            o_wr_area      <= bbx_pkg::area_short_direct;
            o_wr_data      <= 8'h00;
            o_illegal      <= 1'b0;
        end else if (accept) begin
            op_q           <= i_op;
            status_q       <= is_status;
            bit_q          <= i_bit_sel;
            bank_q         <= i_bank_sel;
            wr_pend_q      <= writes;
            div_q          <= i_cpu_clock_divider_select;
            o_length       <= length;
            o_clocks       <= clocks;
            o_pc_next      <= cond ? pc_target : pc_seq;
            o_branch_taken <= cond;
            o_wr_area      <= i_area;
            o_wr_data      <= wr_byte;
            o_illegal      <= (i_op == bbx_pkg::op_word_move) && !pair_ok; // see RULE20
        end
    end

    // Status word register.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            psw_q <= bbx_pkg::PSW_RESET;
        end else begin
            psw_q <= psw_d;
        end
    end

    // Standby flags; entry at completion wins over a wake in the same cycle.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            pause_q <= 1'b0;
            osc_q   <= 1'b0;
        end else begin
            pause_q <= (last && op_q == bbx_pkg::op_clock_pause) ||
                       (pause_q && !i_wake); // see RULE18
            osc_q   <= (last && op_q == bbx_pkg::op_osc_off) ||
                       (osc_q && !i_wake); // see RULE19
        end
    end

    // Elapsed system clocks of the running instruction, for checking only.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            elapsed_q <= 8'h00;
        end else begin
            elapsed_q <= accept ? 8'h00 : (busy ? elapsed_q + 8'h01 : elapsed_q);
        end
    end

    // Status word views.
    assign o_program_status_word    = psw_q;
    assign o_global_irq_enable_flag = psw_q[bbx_pkg::PSW_IRQ_POS];
    assign o_bank_choice_bits = {psw_q[bbx_pkg::PSW_BANK1_POS], psw_q[bbx_pkg::PSW_BANK0_POS]};
    assign o_clock_pause = pause_q;
    assign o_osc_off     = osc_q;

    sequence take_s(bbx_pkg::op_t op, bbx_pkg::area_t ar);
        accept && i_op == op && i_area == ar;
    endsequence

    sequence finish_s(bbx_pkg::op_t op);
        last && op_q == op;
    endsequence

    span_exact_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE1
        last |-> (elapsed_q + 8'h01) == ({4'h0, o_clocks} << div_q))
        else $error("Instruction time does not match its clock count.");

    short_set_form_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE3
        take_s(bbx_pkg::op_bit_set, bbx_pkg::area_short_direct)
        |=> o_length == 3'h3 && o_clocks == ($past(i_hs_ram) ? 4'h8 : 4'h9))
        else $error("Short direct bit-set branch form wrong.");

    sfr_set_form_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE4
        take_s(bbx_pkg::op_bit_set, bbx_pkg::area_sfr) |=> o_length == 3'h4 && o_clocks == 4'hb)
        else $error("Special register bit-set branch form wrong.");

    branch_target_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE21
        accept ##1 o_branch_taken |-> o_pc_next == $past(i_pc) + {13'h0000, o_length}
            + {{8{$past(i_relative_offset[7])}}, $past(i_relative_offset)})
        else $error("Branch target is not next address plus offset.");

    zero_test_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE8
        accept && i_op == bbx_pkg::op_bit_zero && src_bit |=> !o_branch_taken)
        else $error("Bit-zero branch taken on a one bit.");

    clear_taken_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE10
        accept && i_op == bbx_pkg::op_set_clear && src_bit && !is_status
        |=> o_branch_taken && !o_wr_data[bit_q] ##[0:96] o_wr_en)
        else $error("Set-and-clear did not clear the tested bit.");

    status_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE11
        finish_s(bbx_pkg::op_set_clear) && status_q && psw_bit |=> !psw_q[$past(bit_q)])
        else $error("Status word bit not cleared.");

    loop_end_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE12
        take_s(bbx_pkg::op_dec_branch, bbx_pkg::area_reg_b) && i_operand == 8'h01
        |=> !o_branch_taken && o_wr_data == 8'h00 && o_clocks == 4'h6)
        else $error("Loop ended wrongly at count one.");

    bank_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE14
        finish_s(bbx_pkg::op_bank_choice) |=> o_bank_choice_bits == $past(bank_q))
        else $error("Bank bits not written.");

    no_action_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE15
        finish_s(bbx_pkg::op_no_action) |=> $stable(psw_q) && !$past(o_wr_en))
        else $error("No-action instruction changed state.");

    irq_enable_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE16
        finish_s(bbx_pkg::op_irq_enable) |=> o_global_irq_enable_flag)
        else $error("Interrupt enable flag not set.");

    irq_mask_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE17
        finish_s(bbx_pkg::op_irq_mask_all) |=> !o_global_irq_enable_flag)
        else $error("Interrupt enable flag not cleared.");

    osc_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE19
        finish_s(bbx_pkg::op_osc_off) |=> o_osc_off && !o_ready)
        else $error("Oscillator-off standby not entered.");

    pair_check_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see RULE20
        accept && i_op == bbx_pkg::op_word_move |=> o_illegal == ($past(i_word_pair) == 2'h0))
        else $error("Word move pair check wrong.");

endmodule : bbx_exec

/* bbx_mem_model.sv */
// Behavioural data memory that feeds operand bytes and takes write-backs.
// Assumes one clock; each byte starts equal to its own address.
`timescale 1ns/1ps
module bbx_mem_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    output logic [7:0]      o_rd_data
);
    logic [7:0] mem [256];
    // Known contents make every operand predictable.
    initial for (int k = 0; k < 256; k++) mem[k] = k[7:0];
    // Reads are immediate; a write-back pulse stores the result.
    assign o_rd_data = mem[i_addr];
    always @(posedge i_sys_clk) if (i_wr_en) mem[i_addr] <= i_wr_data;
endmodule : bbx_mem_model

/* bbx_exec_tb.sv */
// Self-checking bench for the bit-test branch and CPU control unit.
// Assumes the unit and a behavioural data memory on one clock.
`timescale 1ns/1ps
module bbx_exec_tb;
    logic sys_clk = 0, resetn = 0, start = 0, hs = 0, wake = 0, we;
    bbx_pkg::op_t op = bbx_pkg::op_no_action;
    bbx_pkg::area_t ar = bbx_pkg::area_accum;
    logic [2:0] bsel = 3'h0, len, wa;
    logic [7:0] addr = 8'h00, off = 8'h00, opnd, wdat, program_status_word;
    logic [1:0] bank = 2'h0, pair = 2'h1, div = 2'h0, banks;
    logic ready, done, taken, wr_en, irq, pause, osc, ill;
    logic [3:0] clks;
    logic [15:0] pcn;
    int num_errors = 0, cmp_count = 0;
    bbx_exec bbx_exec_i (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_start(start), .i_op(op),
        .i_area(ar), .i_hs_ram(hs), .i_bit_sel(bsel), .i_operand(opnd),
        .i_relative_offset(off), .i_pc(16'h1000), .i_bank_sel(bank), .i_word_pair(pair),
        .i_cpu_clock_divider_select(div), .i_wake(wake), .o_ready(ready), .o_done(done),
        .o_length(len), .o_clocks(clks), .o_pc_next(pcn), .o_branch_taken(taken),
        .o_wr_en(wr_en), .o_wr_area(wa), .o_wr_data(wdat), .o_program_status_word(program_status_word),
        .o_global_irq_enable_flag(irq), .o_bank_choice_bits(banks), .o_clock_pause(pause),
        .o_osc_off(osc), .o_illegal(ill));
    bbx_mem_model bbx_mem_model_i (.i_sys_clk(sys_clk), .i_wr_en(wr_en), .i_addr(addr),
        .i_wr_data(wdat), .o_rd_data(opnd));
    // Clock at 40 MHz.
    always #12.5 sys_clk = ~sys_clk;
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask : check
    // Issues one instruction, waits for completion and judges its results.
    task automatic run(input bbx_pkg::op_t o, input bbx_pkg::area_t a, input logic h,
        input logic [2:0] b, input logic [7:0] ad, input logic [7:0] of,
        input logic [2:0] ln, input logic [3:0] ck, input logic tk);
        int n;
        logic [15:0] exp;
        exp = 16'h1000 + 16'(ln) + (tk ? {{8{of[7]}}, of} : 16'h0000);
        @(posedge sys_clk);
        start <= 1'b1;
        op <= o;
        ar <= a;
        hs <= h;
        bsel <= b;
        addr <= ad;
        off <= of;
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        n = 1;
        while (done !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(16'(n), 16'(ck) << div, "cycle count");
        check(len, ln, "length");
        check(clks, ck, "clocks");
        check(pcn, exp, "next address");
        check(taken, tk, "branch taken");
        we = wr_en;
        @(posedge sys_clk);
        #1;
    endtask : run
    task t_bit_set;
        run(bbx_pkg::op_bit_set, bbx_pkg::area_status, 0, 3'h1, 8'h00, 8'h05, 3, 9, 1);
        run(bbx_pkg::op_bit_set, bbx_pkg::area_short_direct, 1, 3'h1, 8'h02, 8'hf0, 3, 8, 1);
        run(bbx_pkg::op_bit_set, bbx_pkg::area_short_direct, 0, 3'h1, 8'h02, 8'h10, 3, 9, 1);
        run(bbx_pkg::op_bit_set, bbx_pkg::area_sfr, 0, 3'h0, 8'h02, 8'h10, 4, 11, 0);
    endtask : t_bit_set
    task t_bit_zero;
        run(bbx_pkg::op_bit_zero, bbx_pkg::area_accum, 1, 3'h0, 8'h02, 8'h80, 3, 8, 1);
        run(bbx_pkg::op_bit_zero, bbx_pkg::area_pointer, 0, 3'h1, 8'h02, 8'h20, 3, 11, 0);
        run(bbx_pkg::op_bit_zero, bbx_pkg::area_short_direct, 1, 3'h0, 8'h02, 8'h7f, 4, 10, 1);
        run(bbx_pkg::op_bit_zero, bbx_pkg::area_sfr, 0, 3'h1, 8'h02, 8'h20, 4, 11, 0);
    endtask : t_bit_zero
    // A set bit is cleared in memory; a second pass then finds it clear.
    task t_set_clear;
        run(bbx_pkg::op_set_clear, bbx_pkg::area_status, 0, 3'h1, 8'h00, 8'h08, 4, 12,
            1);
        check({we, program_status_word}, 9'h000, "status bit cleared");
        run(bbx_pkg::op_set_clear, bbx_pkg::area_sfr, 0, 3'h2, 8'h06, 8'h08, 4, 12, 1);
        check({we, opnd}, 9'h102, "cleared byte written");
        run(bbx_pkg::op_set_clear, bbx_pkg::area_sfr, 0, 3'h2, 8'h06, 8'h08, 4, 12, 0);
        check(we, 1'b0, "no write when clear");
    endtask : t_set_clear
    task t_loop;
        run(bbx_pkg::op_dec_branch, bbx_pkg::area_reg_b, 1, 3'h0, 8'h01, 8'h04, 2, 6, 0);
        check({wa, opnd}, {bbx_pkg::area_reg_b, 8'h00}, "count reaches zero");
        run(bbx_pkg::op_dec_branch, bbx_pkg::area_short_direct, 0, 3'h0, 8'h05, 8'hfe, 3, 10, 1);
        check(opnd, 8'h04, "byte decremented");
    endtask : t_loop
    // Control instructions, word move pairs and a slower CPU clock.
    task t_control;
        @(posedge sys_clk) bank <= 2'h2;
        run(bbx_pkg::op_bank_choice, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 2, 4, 0);
        check(banks, 2'h2, "bank bits");
        run(bbx_pkg::op_irq_enable, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 2, 6, 0);
        check(irq, 1'b1, "irq enable set");
        run(bbx_pkg::op_irq_mask_all, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 2, 6, 0);
        check({irq, banks}, 3'h2, "irq enable clear");
        @(posedge sys_clk) div <= 2'h2;
        run(bbx_pkg::op_no_action, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 1, 2, 0);
        check(program_status_word, 8'h20, "status word unchanged");
        @(posedge sys_clk) pair <= 2'h0;
        run(bbx_pkg::op_word_move, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 1, 4, 0);
        check(ill, 1'b1, "pair refused");
        @(posedge sys_clk) div <= 2'h0;
        pair <= 2'h3;
        run(bbx_pkg::op_word_move, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 1, 4, 0);
        check(ill, 1'b0, "pair accepted");
    endtask : t_control
    task t_standby;
        run(bbx_pkg::op_clock_pause, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 2, 6, 0);
        check({ready, pause, osc}, 3'h2, "clock pause entered");
        @(posedge sys_clk) wake <= 1'b1;
        @(posedge sys_clk) wake <= 1'b0;
        run(bbx_pkg::op_osc_off, bbx_pkg::area_accum, 1, 3'h0, 8'h00, 8'h00, 2, 6, 0);
        check({ready, pause, osc}, 3'h1, "oscillator off entered");
    endtask : t_standby
    task tally_and_finish;
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // Main sequence after a 20-cycle reset.
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        t_bit_set;
        t_bit_zero;
        t_set_clear;
        t_loop;
        t_control;
        t_standby;
        tally_and_finish;
    end
    // Watchdog well beyond the expected run.
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        tally_and_finish;
    end
endmodule : bbx_exec_tb
